// ---- hdl/slc_pkg.sv ----
package slc_pkg;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_DEV_ID = 7'h03;
  localparam logic [6:0] ADDR_BANK_ID = 7'h04;
  localparam logic [6:0] ADDR_LANES = 7'h05;
  localparam logic [6:0] ADDR_FRAMES = 7'h06;
  localparam logic [6:0] ADDR_MODE = 7'h07;
  localparam logic [6:0] ADDR_SUBCLASS = 7'h08;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DEV_ID = 8'h00;
  localparam logic [3:0] RST_BANK_ID = 4'h0;
  localparam logic [2:0] RST_LANES_M1 = 3'h1;
  localparam logic [4:0] RST_FRAMES_M1 = 5'h0F;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_SUBCLASS = 8'h00;

  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int MODE_ALIGN_SEQ_DIS_BIT = 5;
  localparam int MODE_LANE_MON_DIS_BIT = 4;
  localparam int MODE_FRAME_MON_DIS_BIT = 3;
  localparam int MODE_DIV_RST_DIS_BIT = 1;
  localparam int MODE_SCRAMBLE_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h3B;
  localparam int SUB_DEARM_LSB = 5;
  localparam int SUB_ALERT_BIT = 4;
  localparam int SUB_TX_SYNC_BIT = 3;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [2:0] SUBCLASS_2 = 3'h2;
  localparam logic [2:0] LANES_ONE = 3'h0;
  localparam logic [4:0] SPI_LAST_BIT = 5'h10;
  localparam logic [4:0] SPI_ADDR_DONE = 5'h08;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic wrStb;
    logic [6:0] addr;
    logic [7:0] data;
  } slc_spi_req_t;

  typedef struct packed {
    logic [7:0] deviceId;
    logic [3:0] bankId;
    logic [2:0] laneCountM1;
    logic [4:0] framesM1;
    logic [7:0] mode;
    logic [7:0] subclass;
  } slc_regs_t;

  typedef struct packed {
    logic [7:0] deviceId;
    logic [3:0] bankId;
    logic [2:0] laneCountM1;
    logic [4:0] framesM1;
    logic singleLane;
    logic alignSeqEnable;
    logic laneMonEnable;
    logic frameMonEnable;
    logic scramblerEnable;
    logic [2:0] subclassSel;
  } slc_link_cfg_t;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_SHIFT = 3'b010,
    SPI_DONE = 3'b100
  } slc_spi_fsm_t;

  typedef struct packed {
    logic [2:0] pinS1;
    logic [2:0] pinS2;
    logic [2:0] pinS3;
    logic [2:0] pinFilt;
    slc_spi_fsm_t fsm;
    logic [4:0] bitCnt;
    logic [15:0] shift;
    logic readOp;
    logic [7:0] rdShift;
    logic sdoOut;
    logic sdoOe;
    slc_spi_req_t req;
  } slc_spi_state_t;

  typedef struct packed {
    slc_regs_t regs;
    slc_link_cfg_t cfg;
    logic [1:0] pinS1;
    logic [1:0] pinS2;
    logic [1:0] pinS3;
    logic [1:0] pinFilt;
    logic [7:0] frameDiv;
    logic [4:0] lmfcCnt;
    logic armed;
    logic [2:0] dearmCnt;
    logic divReset;
    logic lmfcTick;
    logic commaReq;
    logic [4:0] commaCnt;
  } slc_core_state_t;

endpackage

// ---- hdl/slc_spi_slave.sv ----
`timescale 1ns/1ps

module slc_spi_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSdi,
  input wire logic [7:0] rdData,
  output slc_pkg::slc_spi_req_t req,
  output logic sdoOut,
  output logic sdoOe
);

  slc_pkg::slc_spi_state_t stateReg;
  slc_pkg::slc_spi_state_t stateNext;
  logic [2:0] diff;
  logic csLow;
  logic sckRise;
  logic sckFall;

  // ------------------------------------------------------------
  // Pin filter and serial frame sequencer
  // ------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    stateNext.req.wrStb = 1'b0;
    stateNext.pinS1 = {spiSdi, spiSck, spiCsN};
    stateNext.pinS2 = stateReg.pinS1;
    stateNext.pinS3 = stateReg.pinS2;
    diff = stateReg.pinS2 ^ stateReg.pinS3;
    stateNext.pinFilt = (~diff & stateReg.pinS3) | (diff & stateReg.pinFilt);
    csLow = ~stateNext.pinFilt[0];
    sckRise = stateNext.pinFilt[1] & ~stateReg.pinFilt[1];
    sckFall = ~stateNext.pinFilt[1] & stateReg.pinFilt[1];
    case (stateReg.fsm)
      slc_pkg::SPI_IDLE: begin
        stateNext.bitCnt = 5'h00;
        stateNext.sdoOe = 1'b0;
        if (csLow) begin
          stateNext.fsm = slc_pkg::SPI_SHIFT;
        end
      end
      slc_pkg::SPI_SHIFT: begin
        if (!csLow) begin
          stateNext.fsm = slc_pkg::SPI_IDLE;
          stateNext.sdoOe = 1'b0;
        end else if (sckRise) begin
          stateNext.shift = {stateReg.shift[14:0], stateNext.pinFilt[2]};
          stateNext.bitCnt = stateReg.bitCnt + 5'h01;
          if (stateNext.bitCnt == slc_pkg::SPI_ADDR_DONE) begin
            stateNext.readOp = stateNext.shift[7];
            stateNext.req.addr = stateNext.shift[6:0];
          end
          if (stateNext.bitCnt == slc_pkg::SPI_LAST_BIT) begin
            stateNext.req.wrStb = ~stateReg.readOp;
            stateNext.req.data = stateNext.shift[7:0];
            stateNext.fsm = slc_pkg::SPI_DONE;
          end
        end else if (sckFall && stateReg.readOp) begin
          // Read data leaves MSB first on falling edges
          if (stateReg.bitCnt == slc_pkg::SPI_ADDR_DONE) begin
            stateNext.sdoOut = rdData[7];
            stateNext.rdShift = {rdData[6:0], 1'b0};
            stateNext.sdoOe = 1'b1;
          end else if (stateReg.bitCnt > slc_pkg::SPI_ADDR_DONE) begin
            stateNext.sdoOut = stateReg.rdShift[7];
            stateNext.rdShift = {stateReg.rdShift[6:0], 1'b0};
          end
        end
      end
      slc_pkg::SPI_DONE: begin
        if (!csLow) begin
          stateNext.fsm = slc_pkg::SPI_IDLE;
          stateNext.sdoOe = 1'b0;
        end
      end
      default: begin
        stateNext.fsm = slc_pkg::SPI_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= '0;
      stateReg.pinS1 <= 3'h7;
      stateReg.pinS2 <= 3'h7;
      stateReg.pinS3 <= 3'h7;
      stateReg.pinFilt <= 3'h7;
      stateReg.fsm <= slc_pkg::SPI_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign req = stateReg.req;
  assign sdoOut = stateReg.sdoOut;
  assign sdoOe = stateReg.sdoOe;

  sdoIdle_a: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.pinFilt[0] |=> !sdoOe)
    else $error("serial output driven while deselected");

endmodule // slc_spi_slave

// ---- hdl/slc_serial_link_config_regs.sv ----
`timescale 1ns/1ps

// Contract
// - Device identifier resets zero, only for alignment
// - Four-bit bank identifier, resets zero, alignment only
// - Lane field 000 one lane, 001 two
// - Lane count configures lanes and is reported
// - Frames-per-multiframe minus one resets to fifteen
// - Mode bit 4 set disables lane monitor
// - Mode bit 3 set disables frame monitor
// - Mode bit 1 set ignores divider reset
// - Mode bit 0 set enables scrambling
// - De-arm length is field plus one multiframes
// - Alert mode: first pulse arms, later act
// - Phase change sends one comma multiframe
// - Subclass select: 0 none, 1 SYSREF, 2 sync
module slc_serial_link_config_regs #(
  parameter logic [7:0] FRAME_CYCLES = 8'h01
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSdi,
  input wire logic sysrefIn,
  input wire logic syncN,
  output logic sdoOut,
  output logic sdoOe,
  output slc_pkg::slc_link_cfg_t linkCfg,
  output logic dividerReset,
  output logic lmfcTick,
  output logic commaRequest
);

  slc_pkg::slc_core_state_t stateReg;
  slc_pkg::slc_core_state_t stateNext;
  slc_pkg::slc_spi_req_t req;
  logic [7:0] readData;
  logic [1:0] diff;
  logic sysrefRise;
  logic syncRise;
  logic frameEn;
  logic act;
  logic alertOn;
  logic [2:0] subSel;

  // ------------------------------------------------------------
  // Serial configuration port
  // ------------------------------------------------------------
  slc_spi_slave uSpi (
    .clk(clk),
    .reset_n(reset_n),
    .spiCsN(spiCsN),
    .spiSck(spiSck),
    .spiSdi(spiSdi),
    .rdData(readData),
    .req(req),
    .sdoOut(sdoOut),
    .sdoOe(sdoOe)
  );

  // ------------------------------------------------------------
  // Read-back multiplexer
  // ------------------------------------------------------------
  always_comb begin
    case (req.addr)
      slc_pkg::ADDR_DEV_ID: readData = stateReg.regs.deviceId;
      slc_pkg::ADDR_BANK_ID: readData = {4'h0, stateReg.regs.bankId};
      slc_pkg::ADDR_LANES: readData = {5'h00, stateReg.regs.laneCountM1};
      slc_pkg::ADDR_FRAMES: readData = {3'h0, stateReg.regs.framesM1};
      slc_pkg::ADDR_MODE: readData = stateReg.regs.mode;
      slc_pkg::ADDR_SUBCLASS: readData = stateReg.regs.subclass;
      default: readData = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Registers, decode and link timing
  // ------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    stateNext.divReset = 1'b0;
    stateNext.lmfcTick = 1'b0;
    act = 1'b0;
    // Timing pins: change counts when second and third stages agree
    stateNext.pinS1 = {syncN, sysrefIn};
    stateNext.pinS2 = stateReg.pinS1;
    stateNext.pinS3 = stateReg.pinS2;
    diff = stateReg.pinS2 ^ stateReg.pinS3;
    stateNext.pinFilt = (~diff & stateReg.pinS3) | (diff & stateReg.pinFilt);
    sysrefRise = stateNext.pinFilt[0] & ~stateReg.pinFilt[0];
    syncRise = stateNext.pinFilt[1] & ~stateReg.pinFilt[1];

    // Register writes, reserved bits dropped
    if (req.wrStb) begin
      case (req.addr)
        slc_pkg::ADDR_DEV_ID: stateNext.regs.deviceId = req.data;
        slc_pkg::ADDR_BANK_ID: stateNext.regs.bankId = req.data[3:0];
        slc_pkg::ADDR_LANES: stateNext.regs.laneCountM1 = req.data[2:0];
        slc_pkg::ADDR_FRAMES: stateNext.regs.framesM1 = req.data[4:0];
        slc_pkg::ADDR_MODE: begin
          stateNext.regs.mode = req.data & slc_pkg::MODE_WRITE_MASK;
        end
        slc_pkg::ADDR_SUBCLASS: stateNext.regs.subclass = req.data;
        default: begin
        end
      endcase
    end

    // Decoded link configuration, identifiers passed only to alignment
    stateNext.cfg.deviceId = stateNext.regs.deviceId;
    stateNext.cfg.bankId = stateNext.regs.bankId;
    stateNext.cfg.laneCountM1 = stateNext.regs.laneCountM1;
    stateNext.cfg.singleLane =
      (stateNext.regs.laneCountM1 == slc_pkg::LANES_ONE);
    stateNext.cfg.framesM1 = stateNext.regs.framesM1;
    stateNext.cfg.alignSeqEnable =
      ~stateNext.regs.mode[slc_pkg::MODE_ALIGN_SEQ_DIS_BIT];
    stateNext.cfg.laneMonEnable =
      ~stateNext.regs.mode[slc_pkg::MODE_LANE_MON_DIS_BIT];
    stateNext.cfg.frameMonEnable =
      ~stateNext.regs.mode[slc_pkg::MODE_FRAME_MON_DIS_BIT];
    stateNext.cfg.scramblerEnable =
      stateNext.regs.mode[slc_pkg::MODE_SCRAMBLE_BIT];
    stateNext.cfg.subclassSel = stateNext.regs.subclass[2:0];

    // Frame enable divider and multiframe counter
    frameEn = (stateReg.frameDiv == FRAME_CYCLES - 8'h01);
    if (frameEn) begin
      stateNext.frameDiv = 8'h00;
      // Wrap at or above the length so a shortened value never stalls
      if (stateReg.lmfcCnt >= stateReg.regs.framesM1) begin
        stateNext.lmfcCnt = 5'h00;
        stateNext.lmfcTick = 1'b1;
      end else begin
        stateNext.lmfcCnt = stateReg.lmfcCnt + 5'h01;
      end
    end else begin
      stateNext.frameDiv = stateReg.frameDiv + 8'h01;
    end

    // Comma multiframe runs for framesM1 plus one frames
    if (stateReg.commaReq && frameEn) begin
      if (stateReg.commaCnt == 5'h00) begin
        stateNext.commaReq = 1'b0;
      end else begin
        stateNext.commaCnt = stateReg.commaCnt - 5'h01;
      end
    end

    // De-arm after field plus one quiet multiframes
    if (stateNext.lmfcTick && stateReg.armed) begin
      if (stateReg.dearmCnt == 3'h0) begin
        stateNext.armed = 1'b0;
      end else begin
        stateNext.dearmCnt = stateReg.dearmCnt - 3'h1;
      end
    end

    // Divider reset events by subclass
    subSel = stateReg.regs.subclass[2:0];
    alertOn = stateReg.regs.subclass[slc_pkg::SUB_ALERT_BIT];
    if (!stateReg.regs.mode[slc_pkg::MODE_DIV_RST_DIS_BIT]) begin
      case (subSel)
        slc_pkg::SUBCLASS_1: begin
          if (sysrefRise) begin
            if (!alertOn) begin
              act = 1'b1;
            end else if (!stateReg.armed) begin
              stateNext.armed = 1'b1;
              stateNext.dearmCnt =
                stateReg.regs.subclass[slc_pkg::SUB_DEARM_LSB +: 3];
            end else begin
              act = 1'b1;
              stateNext.dearmCnt =
                stateReg.regs.subclass[slc_pkg::SUB_DEARM_LSB +: 3];
            end
          end
        end
        slc_pkg::SUBCLASS_2: begin
          act = syncRise;
        end
        default: begin
          act = 1'b0;
        end
      endcase
    end
    if (!alertOn) begin
      stateNext.armed = 1'b0;
    end

    // Realign dividers; a moved phase triggers the comma multiframe
    if (act) begin
      stateNext.divReset = 1'b1;
      if ((stateReg.frameDiv != 8'h00 || stateReg.lmfcCnt != 5'h00) &&
          stateReg.regs.subclass[slc_pkg::SUB_TX_SYNC_BIT]) begin
        stateNext.commaReq = 1'b1;
        stateNext.commaCnt = stateReg.regs.framesM1;
      end
      stateNext.frameDiv = 8'h00;
      stateNext.lmfcCnt = 5'h00;
      stateNext.lmfcTick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= '0;
      stateReg.regs.deviceId <= slc_pkg::RST_DEV_ID;
      stateReg.regs.bankId <= slc_pkg::RST_BANK_ID;
      stateReg.regs.laneCountM1 <= slc_pkg::RST_LANES_M1;
      stateReg.regs.framesM1 <= slc_pkg::RST_FRAMES_M1;
      stateReg.regs.mode <= slc_pkg::RST_MODE;
      stateReg.regs.subclass <= slc_pkg::RST_SUBCLASS;
      stateReg.cfg.deviceId <= slc_pkg::RST_DEV_ID;
      stateReg.cfg.bankId <= slc_pkg::RST_BANK_ID;
      stateReg.cfg.laneCountM1 <= slc_pkg::RST_LANES_M1;
      stateReg.cfg.framesM1 <= slc_pkg::RST_FRAMES_M1;
      stateReg.cfg.alignSeqEnable <= 1'b1;
      stateReg.cfg.laneMonEnable <= 1'b1;
      stateReg.cfg.frameMonEnable <= 1'b1;
      stateReg.pinS1 <= 2'h2;
      stateReg.pinS2 <= 2'h2;
      stateReg.pinS3 <= 2'h2;
      stateReg.pinFilt <= 2'h2;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign linkCfg = stateReg.cfg;
  assign dividerReset = stateReg.divReset;
  assign lmfcTick = stateReg.lmfcTick;
  assign commaRequest = stateReg.commaReq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  devIdWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
    req.wrStb && req.addr == slc_pkg::ADDR_DEV_ID
    |=> linkCfg.deviceId == $past(req.data))
    else $error("device identifier not updated");

  bankIdWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
    req.wrStb && req.addr == slc_pkg::ADDR_BANK_ID
    |=> linkCfg.bankId == $past(req.data[3:0]))
    else $error("bank identifier not updated");

  laneDecode_a: assert property (@(posedge clk) disable iff (!reset_n)
    linkCfg.singleLane == (linkCfg.laneCountM1 == slc_pkg::LANES_ONE))
    else $error("lane arrangement disagrees with count");

  laneWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
    req.wrStb && req.addr == slc_pkg::ADDR_LANES
    |=> linkCfg.laneCountM1 == $past(req.data[2:0]))
    else $error("lane count not reported");

  lmfcWrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    frameEn && stateReg.lmfcCnt >= stateReg.regs.framesM1
    |=> stateReg.lmfcCnt == 5'h00)
    else $error("multiframe counter missed its wrap");

  alignSeq_a: assert property (@(posedge clk) disable iff (!reset_n)
    req.wrStb && req.addr == slc_pkg::ADDR_MODE
    |=> linkCfg.alignSeqEnable ==
        !$past(req.data[slc_pkg::MODE_ALIGN_SEQ_DIS_BIT]))
    else $error("alignment sequence enable wrong");

  laneMon_a: assert property (@(posedge clk) disable iff (!reset_n)
    linkCfg.laneMonEnable != stateReg.regs.mode[4])
    else $error("lane monitor enable wrong");

  frameMon_a: assert property (@(posedge clk) disable iff (!reset_n)
    linkCfg.frameMonEnable != stateReg.regs.mode[3])
    else $error("frame monitor enable wrong");

  divRstDis_a: assert property (@(posedge clk) disable iff (!reset_n)
    dividerReset |-> !$past(stateReg.regs.mode[1]))
    else $error("divider reset while disabled");

  scramble_a: assert property (@(posedge clk) disable iff (!reset_n)
    req.wrStb && req.addr == slc_pkg::ADDR_MODE
    |=> linkCfg.scramblerEnable == $past(req.data[0]))
    else $error("scrambler enable wrong");

  dearmEnd_a: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.armed && stateReg.dearmCnt == 3'h0 && stateNext.lmfcTick &&
    !act && !sysrefRise |=> !stateReg.armed)
    else $error("arming not released");

  alertArm_a: assert property (@(posedge clk) disable iff (!reset_n)
    sysrefRise && alertOn && !stateReg.armed && subSel == 3'h1 &&
    !stateReg.regs.mode[slc_pkg::MODE_DIV_RST_DIS_BIT]
    |=> !dividerReset && stateReg.armed)
    else $error("first pulse in alert mode acted");

  commaLen_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(commaRequest) |-> $past(stateReg.regs.subclass[3]) &&
    stateReg.commaCnt == $past(stateReg.regs.framesM1))
    else $error("comma multiframe started wrongly");

  subclassZero_a: assert property (@(posedge clk) disable iff (!reset_n)
    dividerReset |-> $past(subSel) == 3'h1 || $past(subSel) == 3'h2)
    else $error("divider reset outside subclass 1 or 2");

  // ------------------------------------------------------------
  // Timing event checks
  // ------------------------------------------------------------

  // Subclass 0 never realigns the dividers
  sub0Quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    subSel == slc_pkg::SUBCLASS_0 |=> !dividerReset)
    else $error("divider reset in subclass 0");

  // Subclass 1 SYSREF edge realigns when enabled
  sysrefAct_a: assert property (@(posedge clk) disable iff (!reset_n)
    sysrefRise && subSel == slc_pkg::SUBCLASS_1 && !alertOn &&
    !stateReg.regs.mode[slc_pkg::MODE_DIV_RST_DIS_BIT] |=> dividerReset)
    else $error("SYSREF edge did not realign");

  // Subclass 2 sync release realigns when enabled
  syncAct_a: assert property (@(posedge clk) disable iff (!reset_n)
    syncRise && subSel == slc_pkg::SUBCLASS_2 &&
    !stateReg.regs.mode[slc_pkg::MODE_DIV_RST_DIS_BIT] |=> dividerReset)
    else $error("sync release did not realign");

  // A realign leaves both counters at zero
  realignZero_a: assert property (@(posedge clk) disable iff (!reset_n)
    dividerReset |-> stateReg.frameDiv == 8'h00 && stateReg.lmfcCnt == 5'h00)
    else $error("counters not cleared by realign");

  // Comma run ends after its last frame
  commaEnd_a: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.commaReq && frameEn && stateReg.commaCnt == 5'h00 && !act
    |=> !commaRequest)
    else $error("comma multiframe overran");

  // A later pulse in alert mode reloads the de-arm count
  dearmReload_a: assert property (@(posedge clk) disable iff (!reset_n)
    sysrefRise && alertOn && stateReg.armed &&
    subSel == slc_pkg::SUBCLASS_1 &&
    !stateReg.regs.mode[slc_pkg::MODE_DIV_RST_DIS_BIT]
    |=> dividerReset &&
        stateReg.dearmCnt == $past(stateReg.regs.subclass[7:5]))
    else $error("de-arm count not reloaded");

endmodule // slc_serial_link_config_regs

// ---- tb/slc_link_partner.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Receiver-side timing pulse source
// ----------------------------------------
module slc_link_partner (
  input wire logic clk,
  output logic sysrefIn,
  output logic syncN
);
  // Idle levels: SYSREF low, sync released high
  initial begin
    sysrefIn = 1'b0;
    syncN = 1'b1;
  end

  // One SYSREF pulse, long enough for the pin filter
  task automatic sysref_pulse();
    @(negedge clk) sysrefIn = 1'b1;
    repeat (6) @(negedge clk);
    sysrefIn = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  // Sync request then release; the release is the event
  task automatic sync_pulse();
    @(negedge clk) syncN = 1'b0;
    repeat (6) @(negedge clk);
    syncN = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule // slc_link_partner

// ---- tb/test_serial_link_config_regs.sv ----
`timescale 1ns/1ps

module test_serial_link_config_regs;
  localparam logic [7:0] FC = 8'h02;
  logic clk, reset_n, spiCsN, spiSck, spiSdi, sysrefIn, syncN;
  logic sdoOut, sdoOe, dividerReset, lmfcTick, commaRequest;
  slc_pkg::slc_link_cfg_t linkCfg;
  int mismatches, num_checks, drCnt, hiCnt;

  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  slc_serial_link_config_regs #(.FRAME_CYCLES(FC)) DUT (
    .clk(clk), .reset_n(reset_n), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiSdi(spiSdi), .sysrefIn(sysrefIn), .syncN(syncN),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .linkCfg(linkCfg),
    .dividerReset(dividerReset), .lmfcTick(lmfcTick),
    .commaRequest(commaRequest)
  );

  slc_link_partner partner (
    .clk(clk), .sysrefIn(sysrefIn), .syncN(syncN)
  );

  // Counts divider realigns and comma cycles
  always @(posedge clk) begin
    drCnt <= drCnt + int'(dividerReset === 1'b1);
    hiCnt <= hiCnt + int'(commaRequest === 1'b1);
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One 16-bit serial frame, each SCK level held 4 clocks
  task automatic spi(input logic rd, input logic [6:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    logic [15:0] w;
    w = {rd, a, d};
    r = 8'h00;
    spiCsN = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      spiSck = 1'b0;
      spiSdi = w[i];
      repeat (4) @(negedge clk);
      if (i < 8) r = {r[6:0], sdoOut};
      if (i == 7) chk({7'h00, sdoOe}, {7'h00, rd});
      spiSck = 1'b1;
      repeat (4) @(negedge clk);
    end
    spiCsN = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi(1'b0, a, d, r);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    spi(1'b1, a, 8'h00, r);
    chk(r, e);
  endtask

  // Waits for the next multiframe tick, n counts clocks
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lmfcTick !== 1'b1 && n < 200);
    if (n >= 200) begin
      mismatches++;
      close_out();
    end
  endtask

  // Sends one timing event and checks the realign count
  task automatic pulse_chk(input logic sys, input int e);
    drCnt = 0;
    if (sys) partner.sysref_pulse();
    else partner.sync_pulse();
    repeat (4) @(negedge clk);
    chk(8'(drCnt), 8'(e));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(slc_pkg::ADDR_DEV_ID, 8'h00);
    rdc(slc_pkg::ADDR_BANK_ID, 8'h00);
    rdc(slc_pkg::ADDR_LANES, 8'h01);
    rdc(slc_pkg::ADDR_FRAMES, 8'h0F);
    rdc(slc_pkg::ADDR_MODE, 8'h00);
    rdc(slc_pkg::ADDR_SUBCLASS, 8'h00);
    chk({3'h0, linkCfg.singleLane, linkCfg.alignSeqEnable,
         linkCfg.laneMonEnable, linkCfg.frameMonEnable,
         linkCfg.scramblerEnable}, 8'h0E);
  endtask

  task automatic t_regs();
    wr(slc_pkg::ADDR_DEV_ID, 8'hA5);
    chk(linkCfg.deviceId, 8'hA5);
    wr(slc_pkg::ADDR_BANK_ID, 8'hFF);
    rdc(slc_pkg::ADDR_BANK_ID, 8'h0F);
    chk({4'h0, linkCfg.bankId}, 8'h0F);
    wr(slc_pkg::ADDR_LANES, 8'h00);
    chk({4'h0, linkCfg.singleLane, linkCfg.laneCountM1}, 8'h08);
    wr(slc_pkg::ADDR_LANES, 8'h01);
    chk({4'h0, linkCfg.singleLane, linkCfg.laneCountM1}, 8'h01);
    wr(slc_pkg::ADDR_FRAMES, 8'h08);
    chk({3'h0, linkCfg.framesM1}, 8'h08);
    wr(slc_pkg::ADDR_MODE, 8'h3B);
    rdc(slc_pkg::ADDR_MODE, 8'h3B);
    chk({4'h0, linkCfg.alignSeqEnable, linkCfg.laneMonEnable,
         linkCfg.frameMonEnable, linkCfg.scramblerEnable}, 8'h01);
    wr(slc_pkg::ADDR_MODE, 8'h00);
    chk({7'h00, linkCfg.frameMonEnable}, 8'h01);
    wr(7'h10, 8'h55);
    rdc(7'h10, 8'h00);
  endtask

  task automatic t_lmfc();
    int n;
    wait_tick(n);
    wait_tick(n);
    chk(8'(n), 8'(9 * FC));
  endtask

  task automatic t_sub();
    pulse_chk(1'b1, 0);
    wr(slc_pkg::ADDR_SUBCLASS, 8'h01);
    chk({5'h00, linkCfg.subclassSel}, 8'h01);
    pulse_chk(1'b1, 1);
    pulse_chk(1'b0, 0);
    wr(slc_pkg::ADDR_MODE, 8'h02);
    pulse_chk(1'b1, 0);
    wr(slc_pkg::ADDR_SUBCLASS, 8'h02);
    pulse_chk(1'b0, 0);
    wr(slc_pkg::ADDR_MODE, 8'h00);
    pulse_chk(1'b0, 1);
    pulse_chk(1'b1, 0);
  endtask

  // Arming, then the 8-multiframe disarm window
  task automatic t_alert();
    wr(slc_pkg::ADDR_SUBCLASS, 8'hF1);
    pulse_chk(1'b1, 0);
    pulse_chk(1'b1, 1);
    repeat (100) @(negedge clk);
    pulse_chk(1'b1, 1);
    repeat (170) @(negedge clk);
    pulse_chk(1'b1, 0);
    pulse_chk(1'b1, 1);
  endtask

  // Event mid-multiframe, comma length in clocks
  task automatic t_comma(input logic [7:0] sub, input int e);
    int n;
    wr(slc_pkg::ADDR_SUBCLASS, sub);
    wait_tick(n);
    repeat (3) @(negedge clk);
    hiCnt = 0;
    partner.sysref_pulse();
    repeat (30) @(negedge clk);
    chk(8'(hiCnt), 8'(e));
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    mismatches = 0;
    num_checks = 0;
    drCnt = 0;
    hiCnt = 0;
    reset_n = 1'b0;
    spiCsN = 1'b1;
    spiSck = 1'b1;
    spiSdi = 1'b1;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_regs();
    t_lmfc();
    t_sub();
    t_alert();
    t_comma(8'h09, 9 * FC);
    t_comma(8'h01, 0);
    close_out();
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule // test_serial_link_config_regs
